//--- design/ehc_cmd_engine.sv
// Purpose: serialises one command frame and collects its short response
// Assumes: fall and rise ticks mark the link clock edges, cmd input synced
// Notes: response crc is not checked; status bits are still returned
`timescale 1ns/1ps
`include "ehc_consts.svh"
module ehc_cmd_engine
  import ehc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_fall,
  input wire logic i_rise,
  input wire logic i_start,
  input wire logic [5:0] i_idx,
  input wire logic [31:0] i_arg,
  input wire logic i_want_resp,
  input wire logic i_cmd_in,
  output logic o_cmd_out,
  output logic o_cmd_oe,
  output logic o_done,
  output logic o_timeout,
  output logic [31:0] o_resp
);
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001, E_SEND = 4'b0010, E_WAIT = 4'b0100, E_RECV = 4'b1000
  } ehc_eng_e;
  ehc_eng_e state_reg;
  logic [47:0] sh_reg;
  logic [46:0] rx_reg;
  logic [6:0] cnt_reg;
  logic want_reg;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= E_IDLE;
      sh_reg <= 48'h0;
      rx_reg <= 47'h0;
      cnt_reg <= 7'h00;
      want_reg <= 1'b0;
      o_cmd_out <= 1'b1;
      o_cmd_oe <= 1'b0;
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      o_resp <= 32'h0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      case (state_reg)
        E_IDLE: begin
          if (i_start) begin
            sh_reg <= {2'b01, i_idx, i_arg, ehc_crc7({2'b01, i_idx, i_arg}), 1'b1};
            cnt_reg <= 7'd48;
            want_reg <= i_want_resp;
            o_timeout <= 1'b0;
            state_reg <= E_SEND;
          end
        end
        E_SEND: begin
          if (i_fall) begin
            if (cnt_reg != 7'h00) begin
              o_cmd_oe <= 1'b1;
              o_cmd_out <= sh_reg[47];
              sh_reg <= {sh_reg[46:0], 1'b1};
              cnt_reg <= cnt_reg - 7'd1;
            end else begin
              // release on the fall after the end bit so the device owns the line for its reply
              o_cmd_oe <= 1'b0;
              o_cmd_out <= 1'b1;
              cnt_reg <= 7'h00;
              state_reg <= want_reg ? E_WAIT : E_IDLE;
              o_done <= !want_reg;
            end
          end
        end
        E_WAIT: begin
          if (i_rise) begin
            if (!i_cmd_in) begin
              cnt_reg <= 7'd47;
              state_reg <= E_RECV;
            end else if (cnt_reg == 7'(`EHC_RESP_WAIT_CLKS)) begin
              o_timeout <= 1'b1;
              o_done <= 1'b1;
              state_reg <= E_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 7'd1;
            end
          end
        end
        E_RECV: begin
          if (i_rise) begin
            rx_reg <= {rx_reg[45:0], i_cmd_in};
            cnt_reg <= cnt_reg - 7'd1;
            if (cnt_reg == 7'd1) begin
              o_resp <= rx_reg[38:7];
              o_done <= 1'b1;
              state_reg <= E_IDLE;
            end
          end
        end
        default: state_reg <= E_IDLE;
      endcase
    end
  end
  a_frame_start_bit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_cmd_oe) |-> !o_cmd_out)
    else $error("command frame did not open with a start bit");
endmodule // ehc_cmd_engine

//--- design/ehc_host_ctrl.sv
// Purpose: host side sequencer for power notice, cache, barrier, code upgrade
// Assumes: software writes an op code; one op at a time; dat0 low means busy
// Notes: host keeps a shadow of the device bytes it writes, since it cannot
//   read the configuration space without a data path
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ehc_consts.svh"
module ehc_host_ctrl
  import ehc_pkg::*;
#(
  parameter int unsigned BUSY_TIMEOUT_CYC = `EHC_BUSY_TIMEOUT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_emmc_clk,
  output logic o_cmd_out,
  output logic o_cmd_oe,
  input wire logic i_cmd_in,
  input wire logic i_dat0,
  output logic o_emmc_rst_n,
  output logic o_busy,
  output logic o_power_safe
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_ISSUE = 6'b000010, S_RESP = 6'b000100,
    S_BUSY = 6'b001000, S_RST = 6'b010000, S_NEXT = 6'b100000
  } ehc_seq_e;
  localparam int LINK_HALF = `EHC_LINK_HALF_CYC;
  localparam int RST_CYC = `EHC_RST_PULSE_CYC;

  function automatic logic [31:0] sw_arg(input logic [7:0] idx, input logic [7:0] val);
    return {6'h00, `EHC_SW_WRITE_BYTE, idx, val, 8'h00};
  endfunction
  function automatic ehc_step_s sw_step(input logic [7:0] idx, input logic [7:0] val,
                                        input logic last);
    return '{last: last, busy_wait: 1'b1, resp: 1'b1, idx: `EHC_CMD_SWITCH,
             arg: sw_arg(idx, val)};
  endfunction
  // what each op sends at each step
  function automatic ehc_step_s plan(input ehc_op_e op, input logic [1:0] st,
                                     input logic [15:0] rca);
    ehc_step_s s;
    s = '{last: 1'b1, busy_wait: 1'b0, resp: 1'b1, idx: `EHC_CMD_STATUS,
          arg: {rca, 16'h0}};
    case (op)
      OP_UPG_ENTER: begin
        if (st == 2'd0) s = sw_step(`EHC_IDX_MODE_CFG, `EHC_MODE_UPGRADE, 1'b0);
        else s = '{last: 1'b1, busy_wait: 1'b0, resp: 1'b1, idx: `EHC_CMD_BLKLEN,
                   arg: `EHC_SECTOR_SIZE};
      end
      OP_UPG_EXIT: s = sw_step(`EHC_IDX_MODE_CFG, `EHC_MODE_NORMAL, 1'b1);
      OP_PON: s = sw_step(`EHC_IDX_NOTICE, `EHC_NOTICE_ON, 1'b1);
      OP_OFF_SHORT: s = sw_step(`EHC_IDX_NOTICE, `EHC_NOTICE_SHORT, 1'b1);
      OP_OFF_LONG: s = sw_step(`EHC_IDX_NOTICE, `EHC_NOTICE_LONG, 1'b1);
      OP_SLEEP: begin
        // notice, then deselect (no reply), then sleep
        if (st == 2'd0) s = sw_step(`EHC_IDX_NOTICE, `EHC_NOTICE_SLEEP, 1'b0);
        else if (st == 2'd1) s = '{last: 1'b0, busy_wait: 1'b0, resp: 1'b0,
                                   idx: `EHC_CMD_SELECT, arg: 32'h0};
        else s = '{last: 1'b1, busy_wait: 1'b1, resp: 1'b1, idx: `EHC_CMD_SLEEP,
                   arg: {rca, 1'b1, 15'h0}};
      end
      OP_WAKE: begin
        if (st == 2'd0) s = '{last: 1'b0, busy_wait: 1'b1, resp: 1'b1,
                              idx: `EHC_CMD_SLEEP, arg: {rca, 16'h0}};
        else s = '{last: 1'b1, busy_wait: 1'b1, resp: 1'b1, idx: `EHC_CMD_SELECT,
                   arg: {rca, 16'h0}};
      end
      OP_CACHE_ON: s = sw_step(`EHC_IDX_CACHE, 8'h01, 1'b1);
      OP_CACHE_OFF: s = sw_step(`EHC_IDX_CACHE, 8'h00, 1'b1);
      OP_FLUSH: s = sw_step(`EHC_IDX_FLUSH, `EHC_FLUSH_BIT, 1'b1);
      OP_BARRIER: s = sw_step(`EHC_IDX_FLUSH, `EHC_BARRIER_BIT, 1'b1);
      OP_BARRIER_EN: s = sw_step(`EHC_IDX_BARRIER_EN, 8'h01, 1'b1);
      OP_GO_IDLE: s = '{last: 1'b1, busy_wait: 1'b0, resp: 1'b0, idx: `EHC_CMD_IDLE,
                        arg: 32'h0};
      default: s = s;
    endcase
    return s;
  endfunction

  // link clock divider: this end makes the clock, so no second domain
  logic [3:0] div_reg;
  logic link_fall;
  logic link_rise;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= 4'h0;
      o_emmc_clk <= 1'b0;
    end else if (i_clk_en) begin
      if (div_reg == 4'(LINK_HALF - 1)) begin
        div_reg <= 4'h0;
        o_emmc_clk <= !o_emmc_clk;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
    end
  end
  assign link_fall = (div_reg == 4'(LINK_HALF - 1)) && o_emmc_clk;
  assign link_rise = (div_reg == 4'(LINK_HALF - 1)) && !o_emmc_clk;

  // pin inputs pass two flops first
  logic cmd_m_reg, cmd_s_reg, dat0_m_reg, dat0_s_reg;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_m_reg <= 1'b1;
      cmd_s_reg <= 1'b1;
      dat0_m_reg <= 1'b1;
      dat0_s_reg <= 1'b1;
    end else if (i_clk_en) begin
      cmd_m_reg <= i_cmd_in;
      cmd_s_reg <= cmd_m_reg;
      dat0_m_reg <= i_dat0;
      dat0_s_reg <= dat0_m_reg;
    end
  end

  // software registers
  logic [15:0] rca_reg;
  logic [31:0] upg_arg_reg;
  logic cap_upg_reg, cap_opcode_reg, cap_barrier_reg;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rca_reg <= 16'h0001;
      upg_arg_reg <= 32'h0;
      cap_upg_reg <= 1'b0;
      cap_opcode_reg <= 1'b0;
      cap_barrier_reg <= 1'b0;
    end else if (i_clk_en && i_wr) begin
      if (i_addr == `EHC_REG_RCA) rca_reg <= i_wdata[15:0];
      if (i_addr == `EHC_REG_UPG_ARG) upg_arg_reg <= i_wdata;
      if (i_addr == `EHC_REG_CAPS) begin
        cap_upg_reg <= i_wdata[0];
        cap_opcode_reg <= i_wdata[1];
        cap_barrier_reg <= i_wdata[2];
      end
    end
  end

  // sequencer
  ehc_seq_e state_reg;
  ehc_op_e op_reg;
  logic [1:0] step_reg;
  logic [31:0] wait_reg;
  logic [31:0] resp_reg;
  logic refused_reg, err_to_reg, err_sw_reg, err_st_reg;
  logic [7:0] notice_reg;
  logic pon_written_reg, asleep_reg, upg_mode_reg, cache_on_reg, barrier_en_reg;
  logic eng_start, eng_done, eng_to;
  logic [31:0] eng_resp;
  ehc_step_s cur;
  ehc_op_e wr_op;
  logic accept, refuse;

  assign cur = plan(op_reg, step_reg, rca_reg);
  assign wr_op = ehc_op_e'(i_wdata[3:0]);
  assign accept = i_clk_en && i_wr && (i_addr == `EHC_REG_OP) && (state_reg == S_IDLE);
  always_comb begin
    refuse = 1'b0;
    case (wr_op)
      OP_NONE: refuse = 1'b1;
      OP_UPG_ENTER: refuse = !cap_upg_reg || asleep_reg;
      OP_OFF_SHORT, OP_OFF_LONG: refuse = !pon_written_reg || asleep_reg;
      OP_SLEEP: refuse = (notice_reg != `EHC_NOTICE_ON) || asleep_reg;
      OP_WAKE: refuse = !asleep_reg;
      OP_BARRIER: refuse = !barrier_en_reg || !cap_barrier_reg || asleep_reg;
      OP_HW_RESET, OP_GO_IDLE: refuse = 1'b0;
      default: refuse = asleep_reg;
    endcase
  end
  assign eng_start = i_clk_en && (state_reg == S_ISSUE);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= S_IDLE;
      op_reg <= OP_NONE;
      step_reg <= 2'd0;
      wait_reg <= 32'h0;
      resp_reg <= 32'h0;
      refused_reg <= 1'b0;
      err_to_reg <= 1'b0;
      err_sw_reg <= 1'b0;
      err_st_reg <= 1'b0;
      o_emmc_rst_n <= 1'b1;
      o_busy <= 1'b0;
    end else if (i_clk_en) begin
      case (state_reg)
        S_IDLE: begin
          if (accept) begin
            // errors clear when an op is written in idle, refused or not; err_st_reg is also rewritten by each later reply of the same op
            refused_reg <= refuse;
            err_to_reg <= 1'b0;
            err_sw_reg <= 1'b0;
            err_st_reg <= 1'b0;
            if (!refuse) begin
              op_reg <= wr_op;
              step_reg <= 2'd0;
              wait_reg <= 32'h0;
              o_busy <= 1'b1;
              if (wr_op == OP_HW_RESET) begin
                o_emmc_rst_n <= 1'b0;
                state_reg <= S_RST;
              end else begin
                state_reg <= S_ISSUE;
              end
            end
          end
        end
        S_ISSUE: state_reg <= S_RESP;
        S_RESP: begin
          if (eng_done) begin
            resp_reg <= eng_resp;
            wait_reg <= 32'h0;
            if (eng_to) begin
              err_to_reg <= 1'b1;
              state_reg <= S_IDLE;
              o_busy <= 1'b0;
            end else begin
              if (cur.idx == `EHC_CMD_SWITCH) err_sw_reg <= eng_resp[`EHC_RSP_SWITCH_ERR];
              if (cur.resp) err_st_reg <= |eng_resp[31:19];
              state_reg <= cur.busy_wait ? S_BUSY : S_NEXT;
            end
          end
        end
        S_BUSY: begin
          // the guard lets the device pull dat0 low before we look at it
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg >= 32'(BUSY_TIMEOUT_CYC)) begin
            err_to_reg <= 1'b1;
            state_reg <= S_IDLE;
            o_busy <= 1'b0;
          end else if (wait_reg >= 32'(`EHC_BUSY_GUARD_CYC) && dat0_s_reg) begin
            state_reg <= S_NEXT;
          end
        end
        S_RST: begin
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg == 32'(RST_CYC - 1)) begin
            o_emmc_rst_n <= 1'b1;
            state_reg <= S_IDLE;
            o_busy <= 1'b0;
          end
        end
        S_NEXT: begin
          if (cur.last) begin
            state_reg <= S_IDLE;
            o_busy <= 1'b0;
          end else begin
            step_reg <= step_reg + 2'd1;
            state_reg <= S_ISSUE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // shadow of device state as written by this host
  logic step_ok;
  assign step_ok = (state_reg == S_NEXT) && !err_sw_reg;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      notice_reg <= `EHC_NOTICE_NONE;
      pon_written_reg <= 1'b0;
      asleep_reg <= 1'b0;
      upg_mode_reg <= 1'b0;
      cache_on_reg <= 1'b0;
      barrier_en_reg <= 1'b0;
      o_power_safe <= 1'b0;
    end else if (i_clk_en) begin
      if ((state_reg == S_RST) || (step_ok && op_reg == OP_GO_IDLE)) begin
        notice_reg <= `EHC_NOTICE_NONE;
        pon_written_reg <= 1'b0;
        asleep_reg <= 1'b0;
        upg_mode_reg <= 1'b0;
        cache_on_reg <= 1'b0;
        barrier_en_reg <= 1'b0;
        o_power_safe <= 1'b0;
      end else if (step_ok) begin
        case (op_reg)
          OP_PON: begin
            notice_reg <= `EHC_NOTICE_ON;
            pon_written_reg <= 1'b1;
          end
          OP_OFF_SHORT: begin
            notice_reg <= `EHC_NOTICE_SHORT;
            o_power_safe <= 1'b1;
          end
          OP_OFF_LONG: begin
            notice_reg <= `EHC_NOTICE_LONG;
            o_power_safe <= 1'b1;
          end
          OP_SLEEP: begin
            if (step_reg == 2'd0) notice_reg <= `EHC_NOTICE_SLEEP;
            if (step_reg == 2'd2) asleep_reg <= 1'b1;
          end
          OP_WAKE: begin
            asleep_reg <= 1'b0;
            notice_reg <= `EHC_NOTICE_ON;
          end
          OP_UPG_ENTER: upg_mode_reg <= 1'b1;
          OP_UPG_EXIT: upg_mode_reg <= 1'b0;
          OP_CACHE_ON: cache_on_reg <= 1'b1;
          OP_CACHE_OFF: cache_on_reg <= 1'b0;
          OP_BARRIER_EN: barrier_en_reg <= 1'b1;
          default: notice_reg <= notice_reg;
        endcase
      end else if (accept && !refuse && wr_op != OP_HW_RESET && pon_written_reg &&
                   (notice_reg == `EHC_NOTICE_SHORT || notice_reg == `EHC_NOTICE_LONG)) begin
        // any further command makes the device fall back to powered on
        notice_reg <= `EHC_NOTICE_ON;
        o_power_safe <= 1'b0;
      end
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0;
    end else if (i_clk_en) begin
      o_rdata <= 32'h0;
      if (i_rd) begin
        case (i_addr)
          `EHC_REG_OP: o_rdata <= {28'h0, op_reg};
          `EHC_REG_RCA: o_rdata <= {16'h0, rca_reg};
          `EHC_REG_UPG_ARG: o_rdata <= upg_arg_reg;
          `EHC_REG_CAPS: o_rdata <= {29'h0, cap_barrier_reg, cap_opcode_reg, cap_upg_reg};
          `EHC_REG_STATUS: o_rdata <= {15'h0, o_power_safe, notice_reg, asleep_reg,
                                       barrier_en_reg, cache_on_reg, upg_mode_reg,
                                       err_st_reg, err_sw_reg, err_to_reg, refused_reg};
          `EHC_REG_RESP: o_rdata <= resp_reg;
          default: o_rdata <= 32'h0;
        endcase
      end
    end
  end

  ehc_cmd_engine u_eng (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_clk_en(i_clk_en),
    .i_fall(link_fall),
    .i_rise(link_rise),
    .i_start(eng_start),
    .i_idx(cur.idx),
    .i_arg(cur.arg),
    .i_want_resp(cur.resp),
    .i_cmd_in(cmd_s_reg),
    .o_cmd_out(o_cmd_out),
    .o_cmd_oe(o_cmd_oe),
    .o_done(eng_done),
    .o_timeout(eng_to),
    .o_resp(eng_resp)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_switch(logic [7:0] idx);
    eng_start && cur.idx == `EHC_CMD_SWITCH && cur.arg[23:16] == idx;
  endsequence
  sequence s_upg_exit_req;
    accept && !refuse && wr_op == OP_UPG_EXIT;
  endsequence
  a_upg_cap_gate: assert property (accept && wr_op == OP_UPG_ENTER && !cap_upg_reg
    |=> refused_reg && state_reg == S_IDLE)
    else $error("upgrade mode entered without capability");
  a_blklen_sector: assert property (eng_start && cur.idx == `EHC_CMD_BLKLEN
    |-> cur.arg == `EHC_SECTOR_SIZE && upg_mode_reg)
    else $error("block length not the sector size");
  a_upg_exit_normal: assert property (s_upg_exit_req |-> ##1
    s_switch(`EHC_IDX_MODE_CFG) ##0 cur.arg[15:8] == `EHC_MODE_NORMAL)
    else $error("mode exit did not write normal");
  a_pon_before_off: assert property (s_switch(`EHC_IDX_NOTICE) ##0
    cur.arg[15:8] != `EHC_NOTICE_ON |-> pon_written_reg)
    else $error("power notice sent before powered on");
  a_notice_no_zero: assert property (s_switch(`EHC_IDX_NOTICE)
    |-> cur.arg[15:8] != `EHC_NOTICE_NONE)
    else $error("zero written to power notice");
  a_safe_after_busy: assert property ($rose(o_power_safe)
    |-> $past(state_reg, 2) == S_BUSY && $past(dat0_s_reg, 2))
    else $error("power declared safe while busy");
  a_sleep_after_notice: assert property (eng_start && cur.idx == `EHC_CMD_SLEEP && cur.arg[15]
    |-> notice_reg == `EHC_NOTICE_SLEEP && $past(cur.idx, 3) == `EHC_CMD_SELECT)
    else $error("sleep issued without notice and deselect");
  a_barrier_needs_en: assert property (s_switch(`EHC_IDX_FLUSH) ##0
    cur.arg[15:8] == `EHC_BARRIER_BIT |-> barrier_en_reg)
    else $error("barrier requested before enable");
  a_rst_pulse_len: assert property ($fell(o_emmc_rst_n) |-> (!o_emmc_rst_n)[*8])
    else $error("reset pulse too short");
  a_rst_cache_off: assert property ($rose(o_emmc_rst_n) |-> !cache_on_reg)
    else $error("cache shadow on after reset");
endmodule // ehc_host_ctrl

//--- shared/ehc_consts.svh
// Purpose: constants for the managed-flash host controller
// Assumes: system clock 20 MHz, link clock made here by a divider
// Notes: extended configuration bytes are reached with switch commands
`ifndef EHC_CONSTS_SVH
`define EHC_CONSTS_SVH
`define EHC_IDX_BARRIER_EN 8'h1f
`define EHC_IDX_FLUSH 8'h20
`define EHC_IDX_CACHE 8'h21
`define EHC_IDX_NOTICE 8'h22
`define EHC_IDX_MODE_CFG 8'h1e
`define EHC_IDX_SLEEP_TIME 8'hd8
`define EHC_IDX_BARRIER_CAP 9'h1e6
`define EHC_NOTICE_NONE 8'h00
`define EHC_NOTICE_ON 8'h01
`define EHC_NOTICE_SHORT 8'h02
`define EHC_NOTICE_LONG 8'h03
`define EHC_NOTICE_SLEEP 8'h04
`define EHC_FLUSH_BIT 8'h01
`define EHC_BARRIER_BIT 8'h02
`define EHC_MODE_NORMAL 8'h00
`define EHC_MODE_UPGRADE 8'h01
`define EHC_SECTOR_SIZE 32'h0000_0200
`define EHC_SW_WRITE_BYTE 2'h3
`define EHC_CMD_IDLE 6'h00
`define EHC_CMD_SLEEP 6'h05
`define EHC_CMD_SWITCH 6'h06
`define EHC_CMD_SELECT 6'h07
`define EHC_CMD_STATUS 6'h0d
`define EHC_CMD_BLKLEN 6'h10
`define EHC_RSP_SWITCH_ERR 7
`define EHC_REG_OP 4'h0
`define EHC_REG_RCA 4'h1
`define EHC_REG_UPG_ARG 4'h2
`define EHC_REG_CAPS 4'h3
`define EHC_REG_STATUS 4'h4
`define EHC_REG_RESP 4'h5
`define EHC_SYS_MHZ 20
`define EHC_LINK_CLK_NS 400
`define EHC_LINK_HALF_CYC (`EHC_LINK_CLK_NS * `EHC_SYS_MHZ / 2000)
`define EHC_BUSY_TIMEOUT_US 100000
`define EHC_BUSY_TIMEOUT_CYC (`EHC_BUSY_TIMEOUT_US * `EHC_SYS_MHZ)
`define EHC_RST_PULSE_NS 1000
`define EHC_RST_PULSE_CYC ((`EHC_RST_PULSE_NS * `EHC_SYS_MHZ + 999) / 1000)
`define EHC_BUSY_GUARD_CYC 16
`define EHC_RESP_WAIT_CLKS 64
`endif

//--- shared/ehc_pkg.sv
// Purpose: types shared by the host controller files
// Assumes: nothing beyond the constants header
// Notes: op codes are what software writes to the op register
package ehc_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_UPG_ENTER = 4'h1, OP_UPG_EXIT = 4'h2, OP_PON = 4'h3,
    OP_OFF_SHORT = 4'h4, OP_OFF_LONG = 4'h5, OP_SLEEP = 4'h6, OP_WAKE = 4'h7,
    OP_CACHE_ON = 4'h8, OP_CACHE_OFF = 4'h9, OP_FLUSH = 4'ha, OP_BARRIER = 4'hb,
    OP_BARRIER_EN = 4'hc, OP_GO_IDLE = 4'hd, OP_HW_RESET = 4'he, OP_STATUS = 4'hf
  } ehc_op_e;
  typedef struct packed {
    logic last;
    logic busy_wait;
    logic resp;
    logic [5:0] idx;
    logic [31:0] arg;
  } ehc_step_s;
  function automatic logic [6:0] ehc_crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) c = c ^ 7'h09;
    end
    return c;
  endfunction
endpackage

//--- testbench/ehc_dev_model.sv
// Purpose: behavioural device on the command and busy lines
// Assumes: host changes command bits on falling link edges
// Notes: no crc check; only the notice byte is kept, no data path
`timescale 1ns/1ps
module ehc_dev_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_cmd,
  output logic o_cmd_oe,
  output logic o_cmd,
  output logic o_dat0
);
  logic [47:0] sh = '1;
  logic [47:0] rsp;
  logic [7:0] notice = 8'h00;
  logic [31:0] st = 32'h0000_0900;
  initial begin
    o_cmd_oe = 1'b0;
    o_cmd = 1'b1;
    o_dat0 = 1'b1;
  end
  always @(posedge i_clk) begin
    sh = {sh[46:0], i_cmd};
    if (sh[47:46] == 2'b01 && sh[0]) begin
      if (notice > 8'h01) notice = 8'h01;
      if (sh[45:40] == 6'h00) notice = 8'h00;
      if (sh[45:40] == 6'h06 && sh[31:24] == 8'h22) begin
        if (sh[23:16] == 8'h00 && notice != 8'h00) st[7] = 1'b1;
        else notice = sh[23:16];
      end
      rsp = {2'b00, sh[45:40], st, 8'h01};
      if (sh[45:40] != 6'h00 && !(sh[45:40] == 6'h07 && sh[39:8] == 32'h0)) begin
        repeat (2) @(negedge i_clk);
        o_cmd_oe = 1'b1;
        for (int i = 47; i >= 0; i--) begin
          o_cmd = rsp[i];
          @(negedge i_clk);
        end
        o_cmd_oe = 1'b0;
        st[7] = 1'b0;
        if (sh[45:40] != 6'h10) begin
          o_dat0 = 1'b0;
          repeat (i_slow ? 40 : 3) @(posedge i_clk);
          o_dat0 = 1'b1;
        end
      end
      sh = '1;
    end
  end
endmodule // ehc_dev_model

//--- testbench/ehc_host_ctrl_tb.sv
// Purpose: bench for the host controller
// Assumes: device model answers every addressed command
// Notes: busy limit shortened to keep the run brief
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module ehc_host_ctrl_tb;
  import ehc_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, slow = 0;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic eclk, hoe, hout, doe, dout, dat0, busy, safe, erst;
  wire cmd = hoe ? hout : (doe ? dout : 1'b1);
  int fails = 0, n_tests = 0;
  always #25 clk = ~clk;
  ehc_host_ctrl #(.BUSY_TIMEOUT_CYC(2000)) i_dut (.i_sys_clk(clk), .i_resetn(rstn),
    .i_clk_en(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_emmc_clk(eclk), .o_cmd_out(hout), .o_cmd_oe(hoe), .i_cmd_in(cmd), .i_dat0(dat0),
    .o_emmc_rst_n(erst), .o_busy(busy), .o_power_safe(safe));
  ehc_dev_model i_dev (.i_clk(eclk), .i_slow(slow), .i_cmd(cmd), .o_cmd_oe(doe),
    .o_cmd(dout), .o_dat0(dat0));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdata & m, e)
  endtask
  task automatic op(input logic [3:0] c);
    int k;
    bus(1'b1, 4'h0, {28'h0, c});
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    fails++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rchk(4'h1, 32'hffff_ffff, 32'h1);
    rchk(4'h9, 32'hffff_ffff, 32'h0);
    op(4'h1);
    rchk(4'h4, 32'h1, 32'h1);
    bus(1'b1, 4'h3, 32'h1);
    op(4'h1);
    rchk(4'h4, 32'h11, 32'h10);
    op(4'h2);
    rchk(4'h4, 32'h10, 32'h0);
    $display("test upgrade ended");
    op(4'h4);
    rchk(4'h4, 32'h1, 32'h1);
    op(4'h3);
    rchk(4'h4, 32'hff01, 32'h0100);
    op(4'h8);
    op(4'h9);
    rchk(4'h4, 32'h21, 32'h0);
    op(4'hb);
    rchk(4'h4, 32'h1, 32'h1);
    $display("test cache ended");
    slow <= 1'b1;
    op(4'h6);
    rchk(4'h4, 32'h81, 32'h80);
    op(4'h7);
    rchk(4'h4, 32'hff81, 32'h0100);
    $display("test sleep ended");
    op(4'h4);
    `CHK(safe, 1'b1)
    rchk(4'h4, 32'h1ff03, 32'h10200);
    op(4'h8);
    op(4'hd);
    rchk(4'h4, 32'hff20, 32'h0);
    $display("test power ended");
    bus(1'b1, 4'h3, 32'h5);
    op(4'hc);
    op(4'hb);
    op(4'hb);
    rchk(4'h4, 32'h4f, 32'h40);
    $display("test barrier ended");
    bus(1'b1, 4'h0, 32'he);
    `CHK(erst, 1'b0)
    repeat (25) @(posedge clk);
    #1;
    `CHK(erst, 1'b1)
    `CHK(busy, 1'b0)
    rchk(4'h4, 32'h60, 32'h0);
    $display("test reset ended");
    results();
  end
endmodule // ehc_host_ctrl_tb
